// [logic/condition_and_link_status_bank.v]
// How it works
// - sixteen read-only ejector condition bytes, zero reset
// - bits 0-2: valve protection, evacuation, leakage
// - bits 3-5: threshold missed, free flow, manual
// - control unit byte at index 16, process data
// - bits 0-1: primary and secondary voltage limits
// - bit 2 pressure window, bit 3 ejector warning
// - two communication bytes, one per link master
// - bits 0-3 show connection on ports one-four
`timescale 1ns/100ps
`include "condition_and_link_status_bank_defs.vh"

module condition_and_link_status_bank #(
  parameter EJECTORS       = `EJECTOR_COUNT,
  parameter PRESSURE_SAMPS = `PRESSURE_FILTER
) (
  input  wire                    clock,
  input  wire                    rst,
  input  wire [`ADDR_W-1:0]      addr,
  input  wire [7:0]              wdata,
  input  wire                    wr,
  input  wire                    rd,
  output reg  [7:0]              rdata_q,
  output reg                     access_error_q,
  input  wire [EJECTORS-1:0]     valve_protect,
  input  wire [EJECTORS-1:0]     evac_time_over,
  input  wire [EJECTORS-1:0]     leak_rate_over,
  input  wire [EJECTORS-1:0]     suction_cycle_start,
  input  wire [EJECTORS-1:0]     suction_cycle_end,
  input  wire [EJECTORS-1:0]     upper_vacuum_threshold_reached,
  input  wire [EJECTORS-1:0]     free_flow_vacuum_high,
  input  wire [EJECTORS-1:0]     manual_mode,
  input  wire                    primary_voltage_limit,
  input  wire                    secondary_voltage_limit,
  input  wire [15:0]             supply_pressure_mbar,
  input  wire                    supply_pressure_valid,
  input  wire [1:0]              link_port_one,
  input  wire [1:0]              link_port_two,
  input  wire [1:0]              link_port_three,
  input  wire [1:0]              link_port_four,
  output reg  [7:0]              control_unit_process_data_q
);

  // one-hot read selection
  localparam SEL_NONE = 4'b0001;
  localparam SEL_EJ   = 4'b0010;
  localparam SEL_UNIT = 4'b0100;
  localparam SEL_LINK = 4'b1000;

  // per-ejector condition storage and its warning summary
  reg  [7:0]          ejector_health_flags_q [0:EJECTORS-1];
  wire [EJECTORS-1:0] ejector_warning;
  reg                 any_warning;

  // control unit byte; the cyclic copy is a second flop fed by the same value
  reg  [7:0]          control_unit_q;
  reg  [7:0]          control_unit_d;

  // one status byte per link master
  reg  [7:0]          link_status_q [0:`LINK_MASTER_COUNT-1];

  // supply pressure filter
  reg  [3:0]          pressure_run_q;
  reg  [3:0]          pressure_run_d;
  reg                 pressure_flag_q;
  reg                 pressure_flag_d;
  wire                pressure_out;
  wire [3:0]          pressure_last;

  // host read path
  wire [15:0]         param_field;
  wire [7:0]          index_field;
  wire [7:0]          ejector_read;
  wire [7:0]          link_read;
  reg  [3:0]          read_sel;
  reg  [7:0]          read_value;
  reg  [7:0]          rdata_d;
  reg                 access_error_d;

  assign param_field  = addr[`ADDR_PARAM_MSB:`ADDR_PARAM_LSB];
  assign index_field  = addr[`ADDR_INDEX_MSB:`ADDR_INDEX_LSB];
  assign ejector_read = ejector_health_flags_q[index_field[3:0]];
  assign link_read    = link_status_q[index_field[0]];

  // indices past the end of a table read zero and raise the error flag
  function [3:0] decode;
    input [15:0] param;
    input [7:0]  index;
    reg          is_condition;
    reg          is_link;
    begin
      is_condition = (param == `PARAM_CONDITION);
      is_link      = (param == `PARAM_LINK_STATUS);
      if (is_condition && index < EJECTORS) begin
        decode = SEL_EJ;
      end else if (is_condition && index == `CONTROL_UNIT_INDEX) begin
        decode = SEL_UNIT;
      end else if (is_link && index < `LINK_MASTER_COUNT) begin
        decode = SEL_LINK;
      end else begin
        decode = SEL_NONE;
      end
    end
  endfunction

  // both window edges themselves count as inside the window
  function outside_window;
    input [15:0] mbar;
    begin
      outside_window = (mbar < `PRESSURE_LOW_MBAR) | (mbar > `PRESSURE_HIGH_MBAR);
    end
  endfunction

  // port one lands in bit 0; the upper nibble is never driven
  function [7:0] pack_ports;
    input [3:0] ports;
    begin
      pack_ports = {4'h0, ports};
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < EJECTORS; i = i + 1) begin : g_ejector
      reg  [7:0] flags_d;
      reg        missed_d;
      reg        seen_d;
      reg        seen_q;

      // remembers whether the threshold was touched anywhere in the cycle
      always @* begin
        seen_d = seen_q;
        if (suction_cycle_start[i] | suction_cycle_end[i]) begin
          seen_d = suction_cycle_start[i] & upper_vacuum_threshold_reached[i];
        end else if (upper_vacuum_threshold_reached[i]) begin
          seen_d = 1'b1;
        end
      end

      // a miss found at cycle end wins over a new cycle starting in the same clock;
      // between cycles the last verdict stays readable
      always @* begin
        missed_d = ejector_health_flags_q[i][`EJ_THRESHOLD_MISSED];
        if (suction_cycle_end[i]) begin
          missed_d = ~(seen_q | upper_vacuum_threshold_reached[i]);
        end else if (suction_cycle_start[i]) begin
          missed_d = 1'b0;
        end
      end

      // evacuation and leakage limits are judged upstream; here they are held as levels
      always @* begin
        flags_d                       = `STATUS_RESET;
        flags_d[`EJ_VALVE_PROTECT]    = valve_protect[i];
        flags_d[`EJ_EVAC_TIME_OVER]   = evac_time_over[i];
        flags_d[`EJ_LEAK_RATE_OVER]   = leak_rate_over[i];
        flags_d[`EJ_THRESHOLD_MISSED] = missed_d;
        flags_d[`EJ_FREE_FLOW_HIGH]   = free_flow_vacuum_high[i];
        flags_d[`EJ_MANUAL_MODE]      = manual_mode[i];
      end

      // upper bits are zero in flags_d, so reset and run agree on them
      always @(posedge clock) begin
        if (rst) begin
          ejector_health_flags_q[i] <= `STATUS_RESET;
          seen_q                    <= 1'b0;
        end else begin
          ejector_health_flags_q[i] <= flags_d;
          seen_q                    <= seen_d;
        end
      end

      // valve protection and manual mode count as warnings too
      assign ejector_warning[i] = |ejector_health_flags_q[i];
    end
  endgenerate

  // a single noisy sample must not flag the supply; a few in a row are needed
  assign pressure_out  = supply_pressure_valid &
                         outside_window(supply_pressure_mbar);
  assign pressure_last = PRESSURE_SAMPS[3:0] - 4'h1;

  // invalid samples leave both the run count and the flag where they were
  always @* begin
    pressure_run_d  = pressure_run_q;
    pressure_flag_d = pressure_flag_q;
    if (!supply_pressure_valid) begin
      pressure_run_d  = pressure_run_q;
    end else if (!pressure_out) begin
      pressure_run_d  = 4'h0;
      pressure_flag_d = 1'b0;
    end else if (pressure_run_q < pressure_last) begin
      pressure_run_d  = pressure_run_q + 4'h1;
    end else begin
      pressure_flag_d = 1'b1;
    end
  end

  // the run count stops at its last step, so a long excursion cannot wrap
  always @(posedge clock) begin
    if (rst) begin
      pressure_run_q  <= 4'h0;
      pressure_flag_q <= 1'b0;
    end else begin
      pressure_run_q  <= pressure_run_d;
      pressure_flag_q <= pressure_flag_d;
    end
  end

  // one pending bit anywhere is enough to raise the summary
  always @* begin
    any_warning = |ejector_warning;
  end

  // bits 7:4 stay zero; only four conditions are reported
  always @* begin
    control_unit_d = `STATUS_RESET;
    control_unit_d[`UNIT_PRIMARY_LIMIT]   = primary_voltage_limit;
    control_unit_d[`UNIT_SECONDARY_LIMIT] = secondary_voltage_limit;
    control_unit_d[`UNIT_PRESSURE_LIMIT]  = pressure_flag_q;
    control_unit_d[`UNIT_EJECTOR_WARNING] = any_warning;
  end

  // the cyclic copy takes the same value, so both views never disagree
  always @(posedge clock) begin
    if (rst) begin
      control_unit_q              <= `STATUS_RESET;
      control_unit_process_data_q <= `STATUS_RESET;
    end else begin
      control_unit_q              <= control_unit_d;
      control_unit_process_data_q <= control_unit_d;
    end
  end

  // master m owns bit m of every port pair
  genvar m;
  generate
    for (m = 0; m < `LINK_MASTER_COUNT; m = m + 1) begin : g_master
      wire [7:0] link_d;

      assign link_d = pack_ports({link_port_four[m], link_port_three[m],
                                  link_port_two[m], link_port_one[m]});

      always @(posedge clock) begin
        if (rst) begin
          link_status_q[m] <= `STATUS_RESET;
        end else begin
          link_status_q[m] <= link_d;
        end
      end
    end
  endgenerate

  // unselected tables read as zero so a stray read leaks nothing
  always @* begin
    read_sel   = decode(param_field, index_field);
    read_value = `STATUS_RESET;
    case (read_sel)
      SEL_EJ: begin
        read_value = ejector_read;
      end
      SEL_UNIT: begin
        read_value = control_unit_q;
      end
      SEL_LINK: begin
        read_value = link_read;
      end
      SEL_NONE: begin
        read_value = `STATUS_RESET;
      end
      default: begin
        read_value = `STATUS_RESET;
      end
    endcase
  end

  // a write never reaches storage; it only answers with the error pulse
  always @* begin
    rdata_d        = `STATUS_RESET;
    access_error_d = wr;
    if (rd) begin
      rdata_d = read_value;
      if (read_sel == SEL_NONE) begin
        access_error_d = 1'b1;
      end
    end
  end

  // read data stand for exactly one cycle, straight from flops
  always @(posedge clock) begin
    if (rst) begin
      rdata_q        <= `STATUS_RESET;
      access_error_q <= 1'b0;
    end else begin
      rdata_q        <= rdata_d;
      access_error_q <= access_error_d;
    end
  end

endmodule // condition_and_link_status_bank

// [shared/condition_and_link_status_bank_defs.vh]
`ifndef CONDITION_AND_LINK_STATUS_BANK_DEFS_VH
`define CONDITION_AND_LINK_STATUS_BANK_DEFS_VH

// address layout: parameter offset in the upper bits, sub-index in the low byte
`define ADDR_W              24
`define ADDR_PARAM_MSB      23
`define ADDR_PARAM_LSB      8
`define ADDR_INDEX_MSB      7
`define ADDR_INDEX_LSB      0

`define PARAM_CONDITION     16'h0092
`define PARAM_LINK_STATUS   16'h001F

`define EJECTOR_COUNT       16
`define CONTROL_UNIT_INDEX  8'h10
`define LINK_MASTER_COUNT   2
`define LINK_PORT_COUNT     4

`define EJ_VALVE_PROTECT    0
`define EJ_EVAC_TIME_OVER   1
`define EJ_LEAK_RATE_OVER   2
`define EJ_THRESHOLD_MISSED 3
`define EJ_FREE_FLOW_HIGH   4
`define EJ_MANUAL_MODE      5
`define EJ_FLAG_COUNT       6

`define UNIT_PRIMARY_LIMIT    0
`define UNIT_SECONDARY_LIMIT  1
`define UNIT_PRESSURE_LIMIT   2
`define UNIT_EJECTOR_WARNING  3
`define UNIT_FLAG_COUNT       4

`define STATUS_RESET        8'h00

// pressure window in mbar: 3.5 bar and 5 bar
`define PRESSURE_LOW_MBAR   16'h0DAC
`define PRESSURE_HIGH_MBAR  16'h1388

// consecutive out-of-window samples before the pressure flag rises
`define PRESSURE_FILTER     4

`endif

// [bench/status_bank_chk.sv]
`timescale 1ns/100ps
module status_bank_chk #(parameter EJECTORS = 16) (
  input wire [23:0]         addr,
  input wire                clock,
  input wire                rst,
  input wire                wr,
  input wire                rd,
  input wire [7:0]          rdata_q,
  input wire                access_error_q,
  input wire [EJECTORS-1:0] manual_mode,
  input wire                primary_voltage_limit,
  input wire                secondary_voltage_limit,
  input wire [7:0]          control_unit_process_data_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_reset_clears_all: assert property ($fell(rst) |-> rdata_q == 8'h00 && !access_error_q
    && control_unit_process_data_q == 8'h00) else $error("outputs not zero after reset");
  a_write_refused: assert property (wr |=> access_error_q && rdata_q == 8'h00)
    else $error("write not refused");
  a_unmapped_read: assert property (rd && addr[23:8] != 16'h0092
    && addr[23:8] != 16'h001F |=> access_error_q && rdata_q == 8'h00)
    else $error("unmapped read not flagged");
  a_ejector_read: assert property (rd && addr[23:8] == 16'h0092 && addr[7:0] < 8'h10
    |=> !access_error_q && rdata_q[7:6] == 2'h0) else $error("bad ejector read");
  a_link_read: assert property (rd && addr[23:8] == 16'h001F && addr[7:0] < 8'h02
    |=> !access_error_q && rdata_q[7:4] == 4'h0) else $error("bad link read");
  a_idle_rdata_zero: assert property (!rd |=> rdata_q == 8'h00)
    else $error("read data outside answer cycle");
  a_control_primary: assert property (primary_voltage_limit
    |=> control_unit_process_data_q[0]) else $error("primary limit missing");
  a_control_secondary: assert property (secondary_voltage_limit
    |=> control_unit_process_data_q[1]) else $error("secondary limit missing");
  a_control_warning: assert property (manual_mode != 0
    |-> ##2 control_unit_process_data_q[3]) else $error("ejector warning missing");
endmodule // status_bank_chk
bind condition_and_link_status_bank status_bank_chk #(.EJECTORS(EJECTORS)) chk (.addr(addr),
  .clock(clock), .rst(rst), .wr(wr), .rd(rd), .rdata_q(rdata_q), .access_error_q(access_error_q),
  .manual_mode(manual_mode), .primary_voltage_limit(primary_voltage_limit),
  .secondary_voltage_limit(secondary_voltage_limit),
  .control_unit_process_data_q(control_unit_process_data_q));

// [bench/host_bus.sv]
`timescale 1ns/100ps
module host_bus (
  input  wire        clock,
  output reg  [23:0] addr,
  output reg  [7:0]  wdata,
  output reg         wr,
  output reg         rd,
  input  wire [7:0]  rdata_q
);
  initial begin
    {addr, wdata, wr, rd} = 34'h0;
  end
  // strobe decides the access; address is scrambled when idle so stale values do not help
  task access(input w, input [23:0] a, input [7:0] v, output [7:0] d);
    begin
      @(posedge clock);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= v;
      @(posedge clock);
      {wr, rd} <= 2'b00;
      addr <= ~a;
      wdata <= ~v;
      #1 d = rdata_q;
    end
  endtask
endmodule // host_bus

// [bench/tb_top.sv]
`timescale 1ns/100ps
`include "condition_and_link_status_bank_defs.vh"
module tb_top;
  reg         clock, rst, pv, sv, spv;
  reg  [15:0] vp, et, lr, ss, se, ut, ff, mm, sp;
  reg  [1:0]  l1, l2, l3, l4;
  reg  [7:0]  d;
  wire [23:0] addr;
  wire [7:0]  wdata, rdata_q, pd;
  wire        wr, rd, aerr;
  integer     fails, checks, i;
  condition_and_link_status_bank #(.PRESSURE_SAMPS(1)) uut (.clock(clock), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .access_error_q(aerr),
    .valve_protect(vp), .evac_time_over(et), .leak_rate_over(lr), .suction_cycle_start(ss),
    .suction_cycle_end(se), .upper_vacuum_threshold_reached(ut), .free_flow_vacuum_high(ff),
    .manual_mode(mm), .primary_voltage_limit(pv), .secondary_voltage_limit(sv),
    .supply_pressure_mbar(sp), .supply_pressure_valid(spv), .link_port_one(l1),
    .link_port_two(l2), .link_port_three(l3), .link_port_four(l4),
    .control_unit_process_data_q(pd));
  host_bus host (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task conclude;
    begin
      if (fails == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task cmp8(input [7:0] g, input [7:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("BAD %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task rdc(input [23:0] a, input [7:0] e);
    begin
      host.access(1'b0, a, 8'h00, d);
      cmp8(d, e);
    end
  endtask
  task settle;
    repeat (3) @(posedge clock);
  endtask
  task t_reset;
    begin
      for (i = 0; i < 17; i = i + 1) rdc({`PARAM_CONDITION, i[7:0]}, 8'h00);
      rdc({`PARAM_LINK_STATUS, 8'h01}, 8'h00);
    end
  endtask
  task t_ejector;
    begin
      for (i = 0; i < 6; i = i + 1) if (i != 3) begin
        @(posedge clock);
        {mm[15], ff[15], lr[15], et[15], vp[15]} <= (i < 3) ? (5'h01 << i) : (5'h01 << (i - 1));
        settle;
        rdc({`PARAM_CONDITION, 8'h0F}, 8'h01 << i);
      end
      @(posedge clock);
      {mm, ff, lr, et, vp, ss} <= {80'h0, 16'h0001};
      @(posedge clock);
      {ss, se} <= 32'h0000_0001;
      @(posedge clock);
      se <= 16'h0000;
      settle;
      rdc({`PARAM_CONDITION, 8'h00}, 8'h08);
      // a cycle that reaches the threshold starts clean and ends clean
      @(posedge clock);
      {ut, ss} <= 32'h0001_0001;
      @(posedge clock);
      {ss, se} <= 32'h0000_0001;
      @(posedge clock);
      se <= 16'h0000;
      settle;
      rdc({`PARAM_CONDITION, 8'h00}, 8'h00);
    end
  endtask
  task t_control;
    begin
      @(posedge clock);
      {pv, sv} <= 2'b11;
      settle;
      rdc({`PARAM_CONDITION, `CONTROL_UNIT_INDEX}, 8'h03);
      cmp8(pd, 8'h03);
      @(posedge clock);
      {pv, sv, spv, sp} <= {3'b001, 16'h0DAB};
      settle;
      rdc({`PARAM_CONDITION, `CONTROL_UNIT_INDEX}, 8'h04);
      @(posedge clock);
      sp <= 16'h1388;
      settle;
      rdc({`PARAM_CONDITION, `CONTROL_UNIT_INDEX}, 8'h00);
      @(posedge clock);
      {spv, mm} <= {1'b0, 16'h0004};
      settle;
      rdc({`PARAM_CONDITION, `CONTROL_UNIT_INDEX}, 8'h08);
      cmp8(pd, 8'h08);
    end
  endtask
  task t_link_write;
    begin
      @(posedge clock);
      {l1, l2, l3, l4} <= 8'b01_10_11_00;
      settle;
      rdc({`PARAM_LINK_STATUS, 8'h00}, 8'h05);
      rdc({`PARAM_LINK_STATUS, 8'h01}, 8'h06);
      host.access(1'b1, {`PARAM_CONDITION, 8'h02}, 8'hFF, d);
      cmp8({7'h00, aerr}, 8'h01);
      rdc({`PARAM_CONDITION, 8'h02}, 8'h20);
      rdc({16'h0093, 8'h00}, 8'h00);
      cmp8({7'h00, aerr}, 8'h01);
    end
  endtask
  initial begin
    fails = 0;
    checks = 0;
    rst = 1'b1;
    {vp, et, lr, ss, se, ut, ff, mm, sp} = 144'h0;
    {pv, sv, spv, l1, l2, l3, l4} = 11'h0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_ejector;
    t_control;
    t_link_write;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge clock);
    fails = fails + 1;
    conclude;
  end
endmodule // tb_top
